// ---- src/csv_pkg.sv ----
package csv_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] CSV_OFS_STATUS = 8'h00;
  localparam logic [7:0] CSV_OFS_MASK   = 8'h04;
  localparam logic [7:0] CSV_OFS_SOURCE = 8'h08;
  localparam logic [7:0] CSV_OFS_SRESET = 8'h0C;
  localparam logic [7:0] CSV_OFS_CONFIG = 8'h10;
  localparam logic [7:0] CSV_OFS_SPARE  = 8'h14;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CSV_ST_WARN   = 0;
  localparam int CSV_ST_ALARM  = 1;
  localparam int CSV_ST_RESET  = 2;
  localparam int CSV_ST_STALL  = 3;
  localparam int CSV_ST_EXT    = 4;
  localparam int CSV_SRC_WARN  = 0;
  localparam int CSV_SRC_ALARM = 1;
  localparam int CSV_SRC_RESET = 2;
  localparam int CSV_SRC_DATA  = 3;
  localparam int CSV_SRC_EXT   = 4;
  localparam int CSV_CFG_MODE  = 0;
  localparam int CSV_CFG_CONT  = 2;
  localparam int CSV_CFG_ACT   = 3;
  localparam int CSV_CFG_RATE  = 8;
  localparam int CSV_CFG_PROX  = 16;
  localparam int CSV_SP_SRC    = 3;

  // ---------------------------------------------------------------
  // Reset values, keys and modes
  // ---------------------------------------------------------------
  localparam logic [7:0]  CSV_MASK_RST   = 8'h00;
  localparam logic [23:0] CSV_CONFIG_RST = 24'h000000;
  localparam logic [3:0]  CSV_SPARE_RST  = 4'h0;
  localparam logic [7:0]  CSV_RESET_KEY  = 8'hDE;
  localparam logic [1:0]  CSV_MODE_HAND   = 2'h0;
  localparam logic [1:0]  CSV_MODE_PENDET = 2'h1;
  localparam logic [1:0]  CSV_MODE_PEN_TRIGGER_MODE = 2'h2;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CSV_CLK_MHZ          = 50;
  localparam int CSV_MEAS_PERIOD_TICK = 1024;
  localparam int CSV_RESET_PROC_US    = 1000;
  localparam int CSV_RESET_PROC_CYC   = CSV_RESET_PROC_US * CSV_CLK_MHZ;

  // Temperature codes at which warning and alarm trip.
  localparam logic [11:0] CSV_WARN_CODE  = 12'h780;
  localparam logic [11:0] CSV_ALARM_CODE = 12'h9B0;

endpackage

// ---- src/csv_thermal.sv ----
`timescale 1ns/1ps
module csv_thermal (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        sync_clear,
  input  wire logic        slow_osc_tick,
  input  wire logic        continuous,
  input  wire logic        active,
  input  wire logic        adc_busy,
  input  wire logic        meas_done,
  input  wire logic [11:0] meas_code,
  output logic             meas_start,
  output logic             warning_flag,
  output logic             alarm_flag
);
  import csv_pkg::*;

  logic [9:0] tick_r,   tick_nxt;
  logic       pend_r,   pend_nxt;
  logic       busy_r,   busy_nxt;
  logic       warn_r,   warn_nxt;
  logic       alarm_r,  alarm_nxt;
  logic       start_r,  start_nxt;
  logic       run;

  assign run = continuous | active;

  always_comb begin
    tick_nxt  = tick_r;
    pend_nxt  = pend_r;
    busy_nxt  = busy_r;
    warn_nxt  = warn_r;
    alarm_nxt = alarm_r;
    start_nxt = 1'b0;
    if (!run) begin
      tick_nxt  = 10'h000;
      pend_nxt  = 1'b0;
      warn_nxt  = 1'b0;
      alarm_nxt = 1'b0;
    end else if (slow_osc_tick) begin
      tick_nxt = tick_r + 10'h001;
      if (tick_r == 10'(CSV_MEAS_PERIOD_TICK - 1)) begin
        pend_nxt = 1'b1;
      end
    end
    if (run && pend_r && !busy_r && (continuous || !adc_busy)) begin
      start_nxt = 1'b1;
      pend_nxt  = 1'b0;
      busy_nxt  = 1'b1;
    end
    if (meas_done && busy_r) begin
      busy_nxt = 1'b0;
      if (run) begin
        warn_nxt  = (meas_code >= CSV_WARN_CODE);
        alarm_nxt = (meas_code >= CSV_ALARM_CODE);
      end
    end
    if (sync_clear) begin
      tick_nxt  = 10'h000;
      pend_nxt  = 1'b0;
      busy_nxt  = 1'b0;
      warn_nxt  = 1'b0;
      alarm_nxt = 1'b0;
      start_nxt = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_r  <= 10'h000;
      pend_r  <= 1'b0;
      busy_r  <= 1'b0;
      warn_r  <= 1'b0;
      alarm_r <= 1'b0;
      start_r <= 1'b0;
    end else begin
      tick_r  <= tick_nxt;
      pend_r  <= pend_nxt;
      busy_r  <= busy_nxt;
      warn_r  <= warn_nxt;
      alarm_r <= alarm_nxt;
      start_r <= start_nxt;
    end
  end

  assign meas_start   = start_r;
  assign warning_flag = warn_r;
  assign alarm_flag   = alarm_r;
endmodule

// ---- src/csv_reset_seq.sv ----
`timescale 1ns/1ps
module csv_reset_seq #(
  parameter int PROC_CYCLES = 1000
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic trigger,
  output logic      busy,
  output logic      soft_clear,
  output logic      done
);
  import csv_pkg::*;

  localparam int CW = $clog2(PROC_CYCLES + 1);

  initial begin
    if (PROC_CYCLES < 1) begin
      $error("PROC_CYCLES must be at least 1.");
    end
  end

  typedef enum logic [0:0] {RS_IDLE, RS_BUSY} csv_rs_t;

  csv_rs_t       st_r,   st_nxt;
  logic [CW-1:0] cnt_r,  cnt_nxt;
  logic          clr_r,  clr_nxt;
  logic          done_r, done_nxt;

  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    clr_nxt  = 1'b0;
    done_nxt = 1'b0;
    case (st_r)
      RS_IDLE: begin
        if (trigger) begin
          st_nxt  = RS_BUSY;
          cnt_nxt = '0;
          clr_nxt = 1'b1;
        end
      end
      RS_BUSY: begin
        if (cnt_r == CW'(PROC_CYCLES - 1)) begin
          st_nxt   = RS_IDLE;
          done_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r + CW'(1);
        end
      end
      default: begin
        st_nxt = RS_IDLE;
      end
    endcase
  end

  // A hard reset starts the procedure itself, so the line stays low across it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r   <= RS_BUSY;
      cnt_r  <= '0;
      clr_r  <= 1'b0;
      done_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      clr_r  <= clr_nxt;
      done_r <= done_nxt;
    end
  end

  assign busy       = (st_r == RS_BUSY);
  assign soft_clear = clr_r;
  assign done       = done_r;
endmodule

// ---- src/csv_supervisor.sv ----
`timescale 1ns/1ps
// Function
// - Idle chip without continuous setting skips measuring
// - Measure every 1024 ticks, defer past conversions
// - Continuous setting measures always, even during conversions
// - Compare results to warning and alarm levels
// - Thermal flag edges selectable as interrupt sources
// - Alarm halts touch, proximity, haptics until cool
// - Shutdown discards results, cycling restarts first channel
// - Host reissues manual commands; haptics resumes alone
// - Enabled events pull interrupt line low
// - Mask selects sources; resets always pull line
// - Source register accumulates events until read
// - Read clears sources and releases line
// - Data source waits for channel reads, stalls in hand and pen trigger modes
// - Masked source bits always read zero
// - Status follows blocks, zero when off
// - Any status or source bit on spare pin
// - Power-on holds line low during reset procedure
// - Pin reset pulls line low, host waits
// - Reset sets flag, status read clears it
// - Key write to reset register resets chip
// - Self reset on ESD behaves like others
module csv_supervisor #(
  parameter int RESET_PROC_CYC = csv_pkg::CSV_RESET_PROC_CYC,
  parameter int EXT_N          = 4
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  input  wire logic [3:0]       pstrb,
  output logic                  pready,
  output logic [31:0]           prdata,
  output logic                  pslverr,
  input  wire logic             slow_osc_tick,
  input  wire logic             adc_busy,
  input  wire logic             temp_done,
  input  wire logic [11:0]      temp_code,
  output logic                  temp_start,
  input  wire logic             esd_event,
  input  wire logic             data_ready,
  input  wire logic             channel_data_read,
  input  wire logic [EXT_N-1:0] ext_status,
  input  wire logic [EXT_N-1:0] ext_block_on,
  input  wire logic [EXT_N-1:0] ext_event,
  output logic                  host_interrupt_n,
  output logic                  spare_pin_one,
  output logic                  touch_run,
  output logic                  proximity_run,
  output logic                  haptics_run,
  output logic                  adc_stall,
  output logic                  discard_results,
  output logic                  restart_sequence,
  output logic                  manual_abort,
  output logic [1:0]            touch_mode
);
  import csv_pkg::*;

  initial begin
    if (EXT_N != 4) begin
      $error("EXT_N must be 4 to fill the eight-bit status and source registers.");
    end
    if (RESET_PROC_CYC < 1) begin
      $error("RESET_PROC_CYC must be at least 1.");
    end
  end

  // ---------------------------------------------------------------
  // ESD input synchroniser and edge detect
  // ---------------------------------------------------------------
  logic esd_s1_r, esd_s2_r, esd_s3_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      esd_s1_r <= 1'b0;
      esd_s2_r <= 1'b0;
      esd_s3_r <= 1'b0;
    end else begin
      esd_s1_r <= esd_event;
      esd_s2_r <= esd_s1_r;
      esd_s3_r <= esd_s2_r;
    end
  end

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  logic access, setup, wr_acc, rd_acc, mapped, key_write, rst_busy;

  assign setup  = psel & ~penable;
  assign access = psel & penable;
  assign wr_acc = access & pwrite & ~rst_busy;
  assign rd_acc = access & ~pwrite & ~rst_busy;
  assign mapped = (paddr == CSV_OFS_STATUS) || (paddr == CSV_OFS_MASK) || (paddr == CSV_OFS_SOURCE) ||
                  (paddr == CSV_OFS_SRESET) || (paddr == CSV_OFS_CONFIG) || (paddr == CSV_OFS_SPARE);
  assign key_write = wr_acc && (paddr == CSV_OFS_SRESET) && pstrb[0] &&
                     (pwdata[7:0] == CSV_RESET_KEY);

  // ---------------------------------------------------------------
  // Reset procedure
  // ---------------------------------------------------------------
  logic soft_clear, rst_done;

  csv_reset_seq #(
    .PROC_CYCLES (RESET_PROC_CYC)
  ) u_reset (
    .pclk       (pclk),
    .presetn    (presetn),
    .trigger    (key_write | (esd_s2_r & ~esd_s3_r)),
    .busy       (rst_busy),
    .soft_clear (soft_clear),
    .done       (rst_done)
  );

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic [7:0]  mask_r,   mask_nxt;
  logic [23:0] cfg_r,    cfg_nxt;
  logic [3:0]  spare_r,  spare_nxt;

  function automatic logic [31:0] csv_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return res;
  endfunction

  always_comb begin
    mask_nxt  = mask_r;
    cfg_nxt   = cfg_r;
    spare_nxt = spare_r;
    if (wr_acc && paddr == CSV_OFS_MASK) begin
      mask_nxt = 8'(csv_merge({24'h000000, mask_r}, pwdata, pstrb));
    end
    if (wr_acc && paddr == CSV_OFS_CONFIG) begin
      cfg_nxt = 24'(csv_merge({8'h00, cfg_r}, pwdata, pstrb));
    end
    if (wr_acc && paddr == CSV_OFS_SPARE) begin
      spare_nxt = 4'(csv_merge({28'h0000000, spare_r}, pwdata, pstrb));
    end
    if (soft_clear) begin
      mask_nxt  = CSV_MASK_RST;
      cfg_nxt   = CSV_CONFIG_RST;
      spare_nxt = CSV_SPARE_RST;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r  <= CSV_MASK_RST;
      cfg_r   <= CSV_CONFIG_RST;
      spare_r <= CSV_SPARE_RST;
    end else begin
      mask_r  <= mask_nxt;
      cfg_r   <= cfg_nxt;
      spare_r <= spare_nxt;
    end
  end

  logic [1:0] mode;
  logic       continuous, chip_active, stall_mode;
  logic [1:0] act_type;
  logic [3:0] rate;
  logic [7:0] prox_int;

  assign mode        = cfg_r[CSV_CFG_MODE +: 2];
  assign continuous  = cfg_r[CSV_CFG_CONT];
  assign act_type    = cfg_r[CSV_CFG_ACT +: 2];
  assign rate        = cfg_r[CSV_CFG_RATE +: 4];
  assign prox_int    = cfg_r[CSV_CFG_PROX +: 8];
  assign chip_active = (mode != CSV_MODE_HAND) || (prox_int != 8'h00) || (act_type != 2'h0);
  assign stall_mode  = (mode == CSV_MODE_HAND) || (mode == CSV_MODE_PEN_TRIGGER_MODE);

  // ---------------------------------------------------------------
  // Temperature supervision
  // ---------------------------------------------------------------
  logic warn_flag, alarm_flag;

  csv_thermal u_thermal (
    .pclk          (pclk),
    .presetn       (presetn),
    .sync_clear    (soft_clear),
    .slow_osc_tick (slow_osc_tick),
    .continuous    (continuous),
    .active        (chip_active),
    .adc_busy      (adc_busy),
    .meas_done     (temp_done),
    .meas_code     (temp_code),
    .meas_start    (temp_start),
    .warning_flag  (warn_flag),
    .alarm_flag    (alarm_flag)
  );

  // ---------------------------------------------------------------
  // Status, sources and shutdown control
  // ---------------------------------------------------------------
  logic [7:0] src_r,    src_nxt;
  logic       rocc_r,   rocc_nxt;
  logic       warn_d_r, warn_d_nxt;
  logic       alrm_d_r, alrm_d_nxt;
  logic       disc_r,   disc_nxt;
  logic       rest_r,   rest_nxt;
  logic       abort_r,  abort_nxt;
  logic [7:0] status, events;
  logic       src_clear;

  assign status = {ext_status & ext_block_on,
                   src_r[CSV_SRC_DATA] & stall_mode,
                   rocc_r, alarm_flag, warn_flag};
  assign events = {ext_event,
                   data_ready,
                   rst_done,
                   alarm_flag ^ alrm_d_r,
                   warn_flag ^ warn_d_r};
  assign src_clear = (rd_acc && paddr == CSV_OFS_SOURCE && !(src_r[CSV_SRC_DATA] && stall_mode)) ||
                     (channel_data_read && src_r[CSV_SRC_DATA] && stall_mode);

  always_comb begin
    src_nxt    = src_r;
    rocc_nxt   = rocc_r;
    warn_d_nxt = warn_flag;
    alrm_d_nxt = alarm_flag;
    disc_nxt   = 1'b0;
    rest_nxt   = 1'b0;
    abort_nxt  = 1'b0;
    if (src_clear) begin
      src_nxt = 8'h00;
    end
    src_nxt = src_nxt | (events & mask_r);
    if (rd_acc && paddr == CSV_OFS_STATUS) begin
      rocc_nxt = 1'b0;
    end
    if (rst_done) begin
      rocc_nxt = 1'b1;
    end
    if (alarm_flag && !alrm_d_r) begin
      disc_nxt  = 1'b1;
      abort_nxt = (mode == CSV_MODE_HAND);
    end
    if (!alarm_flag && alrm_d_r && rate != 4'h0) begin
      rest_nxt = 1'b1;
    end
    if (soft_clear) begin
      src_nxt  = 8'h00;
      disc_nxt = 1'b0;
      rest_nxt = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_r    <= 8'h00;
      rocc_r   <= 1'b0;
      warn_d_r <= 1'b0;
      alrm_d_r <= 1'b0;
      disc_r   <= 1'b0;
      rest_r   <= 1'b0;
      abort_r  <= 1'b0;
    end else begin
      src_r    <= src_nxt;
      rocc_r   <= rocc_nxt;
      warn_d_r <= warn_d_nxt;
      alrm_d_r <= alrm_d_nxt;
      disc_r   <= disc_nxt;
      rest_r   <= rest_nxt;
      abort_r  <= abort_nxt;
    end
  end

  logic [7:0] src_vis;

  assign src_vis = src_r & mask_r;

  // ---------------------------------------------------------------
  // Read data, line and pin outputs
  // ---------------------------------------------------------------
  logic [31:0] rdata_r, rdata_nxt;
  logic        err_r,   err_nxt;
  logic        irq_n_r, irq_n_nxt;
  logic        spare_o_r, spare_o_nxt;

  always_comb begin
    rdata_nxt = rdata_r;
    err_nxt   = err_r;
    if (setup) begin
      rdata_nxt = 32'h00000000;
      err_nxt   = !mapped || rst_busy;
      if (!pwrite) begin
        case (paddr)
          CSV_OFS_STATUS: rdata_nxt = {24'h000000, status};
          CSV_OFS_MASK:   rdata_nxt = {24'h000000, mask_r};
          CSV_OFS_SOURCE: rdata_nxt = {24'h000000, src_vis};
          CSV_OFS_CONFIG: rdata_nxt = {8'h00, cfg_r};
          CSV_OFS_SPARE:  rdata_nxt = {28'h0000000, spare_r};
          default:        rdata_nxt = 32'h00000000;
        endcase
      end
    end
    irq_n_nxt   = !(rst_busy || (src_vis != 8'h00));
    spare_o_nxt = spare_r[CSV_SP_SRC] ? src_vis[spare_r[2:0]] : status[spare_r[2:0]];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r   <= 32'h00000000;
      err_r     <= 1'b0;
      irq_n_r   <= 1'b0;
      spare_o_r <= 1'b0;
    end else begin
      rdata_r   <= rdata_nxt;
      err_r     <= err_nxt;
      irq_n_r   <= irq_n_nxt;
      spare_o_r <= spare_o_nxt;
    end
  end

  assign pready           = 1'b1;
  assign prdata           = rdata_r;
  assign pslverr          = access & err_r;
  assign host_interrupt_n = irq_n_r;
  assign spare_pin_one    = spare_o_r;
  assign touch_run        = !alarm_flag && !rst_busy && (mode != CSV_MODE_HAND);
  assign proximity_run    = !alarm_flag && !rst_busy && (prox_int != 8'h00);
  assign haptics_run      = !alarm_flag && !rst_busy && (act_type != 2'h0);
  assign adc_stall        = (src_r[CSV_SRC_DATA] && stall_mode) || alarm_flag;
  assign discard_results  = disc_r;
  assign restart_sequence = rest_r;
  assign manual_abort     = abort_r;
  assign touch_mode       = mode;
endmodule

// ---- tb/csv_sensor_model.sv ----
`timescale 1ns/1ps
module csv_sensor_model #(
  parameter int LAT = 4
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        temp_start,
  input  wire logic [11:0] code_in,
  output logic             temp_done,
  output logic [11:0]      temp_code
);
  int         cnt;
  logic [11:0] last;
  // The result bus shows the inverse of the last result outside its valid cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      temp_done <= 1'b0;
      temp_code <= 12'h000;
      last <= 12'h000;
    end else begin
      temp_done <= 1'b0;
      temp_code <= ~last;
      if (temp_start) begin
        cnt <= LAT;
      end else if (cnt == 1) begin
        cnt <= 0;
        temp_done <= 1'b1;
        temp_code <= code_in;
        last <= code_in;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

// ---- tb/csv_supervisor_props.sv ----
`timescale 1ns/1ps
module csv_supervisor_chk #(
  parameter int EXT_N = 4
) (
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic [31:0]      pwdata,
  input wire logic             pready,
  input wire logic [31:0]      prdata,
  input wire logic             pslverr,
  input wire logic             temp_start,
  input wire logic [EXT_N-1:0] ext_event,
  input wire logic             host_interrupt_n,
  input wire logic             touch_run,
  input wire logic             haptics_run,
  input wire logic             discard_results
);
  import csv_pkg::*;
  logic [7:0] mask_r;
  logic [7:0] mask_nxt;
  logic       wr_ok;
  logic       key_wr;
  assign wr_ok = psel && penable && pwrite && !pslverr;
  assign key_wr = wr_ok && paddr == CSV_OFS_SRESET && pwdata[7:0] == CSV_RESET_KEY;
  // Shadow of the mask, followed by snooping accepted writes.
  always_comb begin
    mask_nxt = mask_r;
    if (wr_ok && paddr == CSV_OFS_MASK) mask_nxt = pwdata[7:0];
    if (key_wr) mask_nxt = CSV_MASK_RST;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mask_r <= CSV_MASK_RST;
    else mask_r <= mask_nxt;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_always: assert property (pready) else $error("pready low");
  a_reset_line_low: assert property ($rose(presetn) |-> !host_interrupt_n)
    else $error("line high right after reset");
  a_unmapped_err: assert property (psel && penable && paddr == 8'h18 |-> pslverr)
    else $error("unmapped access without error");
  a_halt_all: assert property (discard_results |-> !touch_run && !haptics_run)
    else $error("block running during thermal shutdown");
  a_discard_halts: assert property (discard_results |-> ##[0:2] !haptics_run)
    else $error("discard without halt");
  a_start_spaced: assert property (temp_start |=> !temp_start [*8])
    else $error("measurements too close");
  a_event_irq: assert property (ext_event[0] && mask_r[4] |-> ##[1:2] !host_interrupt_n)
    else $error("enabled event left line high");
  a_masked_zero: assert property (psel && penable && !pwrite && !pslverr && paddr == CSV_OFS_SOURCE
    |-> (prdata[7:0] & ~mask_r) == 8'h00)
    else $error("masked source bit read as one");
  a_key_resets: assert property (key_wr |-> ##[1:4] !host_interrupt_n)
    else $error("key write left line high");
  c_discard: cover property (discard_results);
  c_release: cover property (!host_interrupt_n ##1 host_interrupt_n);
  c_measure: cover property (temp_start);
endmodule
bind csv_supervisor csv_supervisor_chk #(.EXT_N(EXT_N)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .temp_start(temp_start), .ext_event(ext_event), .host_interrupt_n(host_interrupt_n),
  .touch_run(touch_run), .haptics_run(haptics_run), .discard_results(discard_results));

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, (e), (g)); end end
module testbench;
  import csv_pkg::*;
  localparam int RP = 20;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, temp_start, temp_done, host_interrupt_n, touch_run, haptics_run, spare_pin_one, e;
  logic [11:0] temp_code, sense_code = 12'h000;
  logic        slow_osc_tick = 0, adc_busy = 0, esd_event = 0, data_ready = 0, channel_data_read = 0;
  logic [3:0]  ext_status = 4'h0, ext_block_on = 4'h0, ext_event = 4'h0;
  int          err_total = 0, checks_done = 0, cyc = 0, starts = 0;
  always #10 pclk = ~pclk;
  csv_supervisor #(.RESET_PROC_CYC(RP), .EXT_N(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .slow_osc_tick(slow_osc_tick), .adc_busy(adc_busy),
    .temp_done(temp_done), .temp_code(temp_code), .temp_start(temp_start), .esd_event(esd_event),
    .data_ready(data_ready), .channel_data_read(channel_data_read), .ext_status(ext_status),
    .ext_block_on(ext_block_on), .ext_event(ext_event), .host_interrupt_n(host_interrupt_n),
    .spare_pin_one(spare_pin_one), .touch_run(touch_run), .proximity_run(), .haptics_run(haptics_run),
    .adc_stall(), .discard_results(), .restart_sequence(), .manual_abort(), .touch_mode());
  csv_sensor_model u_sens (.pclk(pclk), .presetn(presetn), .temp_start(temp_start), .code_in(sense_code),
    .temp_done(temp_done), .temp_code(temp_code));
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      slow_osc_tick <= 1'b1;
      @(posedge pclk);
      slow_osc_tick <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task automatic pulse(input logic [3:0] v);
    ext_event <= v;
    @(posedge pclk);
    ext_event <= 4'h0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic wait_high();
    int n;
    n = 0;
    while (host_interrupt_n !== 1'b1 && n < RP + 10) begin
      @(posedge pclk);
      n++;
    end
    `CHK("irq release", 1'b1, host_interrupt_n)
  endtask
  task automatic t_reset();
    `CHK("irq in reset", 1'b0, host_interrupt_n)
    wait_high();
    apb(0, CSV_OFS_STATUS, 0);
    `CHK("reset flag", 1'b1, q[CSV_ST_RESET])
    apb(0, CSV_OFS_STATUS, 0);
    `CHK("flag cleared", 1'b0, q[CSV_ST_RESET])
    apb(0, CSV_OFS_MASK, 0);
    `CHK("mask default", CSV_MASK_RST, q[7:0])
  endtask
  task automatic t_irq();
    ext_block_on <= 4'hF;
    ext_status <= 4'hA;
    apb(1, CSV_OFS_MASK, 32'h30);
    pulse(4'h1);
    `CHK("irq low", 1'b0, host_interrupt_n)
    pulse(4'h6);
    apb(0, CSV_OFS_SOURCE, 0);
    `CHK("source", 8'h30, q[7:0])
    repeat (3) @(posedge pclk);
    `CHK("irq freed", 1'b1, host_interrupt_n)
    apb(0, CSV_OFS_SOURCE, 0);
    `CHK("source clr", 8'h00, q[7:0])
    apb(0, CSV_OFS_STATUS, 0);
    `CHK("ext on", 4'hA, q[7:4])
    ext_block_on <= 4'h3;
    repeat (3) @(posedge pclk);
    apb(0, CSV_OFS_STATUS, 0);
    `CHK("ext off", 4'h2, q[7:4])
    apb(1, CSV_OFS_SPARE, 32'h5);
    @(posedge pclk);
    `CHK("spare pin", 1'b1, spare_pin_one)
  endtask
  task automatic t_thermal();
    apb(1, CSV_OFS_MASK, 32'h03);
    ticks(1024);
    `CHK("idle starts", 0, starts)
    adc_busy <= 1'b1;
    sense_code <= CSV_ALARM_CODE;
    apb(1, CSV_OFS_CONFIG, 32'h4);
    ticks(1023);
    `CHK("early start", 0, starts)
    ticks(1);
    repeat (12) @(posedge pclk);
    `CHK("start", 1, starts)
    apb(0, CSV_OFS_STATUS, 0);
    `CHK("hot flags", 2'b11, q[1:0])
    apb(1, CSV_OFS_CONFIG, 32'hD);
    `CHK("halted", 1'b0, touch_run)
    apb(0, CSV_OFS_SOURCE, 0);
    `CHK("hot source", 2'b11, q[1:0])
    sense_code <= 12'h000;
    ticks(1024);
    repeat (12) @(posedge pclk);
    apb(0, CSV_OFS_STATUS, 0);
    `CHK("cool flags", 2'b00, q[1:0])
    `CHK("resumed", 1'b1, touch_run)
    `CHK("haptics back", 1'b1, haptics_run)
    apb(0, CSV_OFS_SOURCE, 0);
    adc_busy <= 1'b0;
  endtask
  task automatic t_soft();
    apb(1, CSV_OFS_MASK, 32'h55);
    apb(1, CSV_OFS_SRESET, 32'h12);
    apb(0, CSV_OFS_MASK, 0);
    `CHK("bad key", 8'h55, q[7:0])
    apb(0, 8'h18, 0);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0, q)
    apb(1, CSV_OFS_SRESET, {24'h0, CSV_RESET_KEY});
    repeat (2) @(posedge pclk);
    `CHK("soft irq", 1'b0, host_interrupt_n)
    wait_high();
    apb(0, CSV_OFS_MASK, 0);
    `CHK("mask reset", CSV_MASK_RST, q[7:0])
    apb(0, CSV_OFS_STATUS, 0);
    `CHK("soft flag", 1'b1, q[CSV_ST_RESET])
  endtask
  task automatic t_stall();
    apb(1, CSV_OFS_MASK, 32'h08);
    data_ready <= 1'b1;
    @(posedge pclk);
    data_ready <= 1'b0;
    repeat (2) apb(0, CSV_OFS_SOURCE, 0);
    `CHK("held src", 8'h08, q[7:0])
    `CHK("held irq", 1'b0, host_interrupt_n)
    channel_data_read <= 1'b1;
    @(posedge pclk);
    channel_data_read <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK("data freed", 1'b1, host_interrupt_n)
  endtask
  task automatic t_esd();
    esd_event <= 1'b1;
    repeat (5) @(posedge pclk);
    `CHK("esd irq", 1'b0, host_interrupt_n)
    esd_event <= 1'b0;
    wait_high();
    apb(0, CSV_OFS_STATUS, 0);
    `CHK("esd flag", 1'b1, q[CSV_ST_RESET])
  endtask
  task automatic results();
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Counts measurement starts and cuts a hung run short.
  always @(posedge pclk) begin
    cyc++;
    if (temp_start === 1'b1) starts++;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_irq();
    t_thermal();
    t_soft();
    t_stall();
    t_esd();
    results();
  end
endmodule
